// >>> lcdcd_chk.sv
// Port assertions for the command decoder
`timescale 1ns/100ps
module lcdcd_chk
   import lcdcd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] cmd_byte_i,
   input wire logic cmd_valid_i,
   input wire logic display_on_i,
   input wire lcdcd_cfg_t cfg_o,
   input wire logic soft_reset_o,
   input wire logic pixels_force_on_o,
   input wire logic pixels_force_off_o,
   input wire logic frame_tick_o,
   input wire logic blink_blank_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Reset pulse wins over a command in the same cycle
   logic take;
   assign take = cmd_valid_i && cmd_byte_i[7] && !soft_reset_o;
   sequence rst_seq;
      soft_reset_o ##1 (!soft_reset_o && cfg_o == 10'h200);
   endsequence
   a_data_ignored: assert property (cmd_valid_i && !cmd_byte_i[7] && !soft_reset_o |=> $stable(cfg_o))
      else $error("data byte changed settings");
   a_disp_ctrl: assert property (take && cmd_byte_i[6:5] == 2'h1
      |=> {cfg_o.frame_freq, cfg_o.waveform_select_bit, cfg_o.current_mode} == $past(cmd_byte_i[4:0]))
      else $error("display control not latched");
   a_osc_source: assert property (take && cmd_byte_i[6:3] == 4'hD && !cmd_byte_i[1]
      |=> cfg_o.osc_source_bit == $past(cmd_byte_i[0]))
      else $error("oscillator source not latched");
   a_soft_reset: assert property (take && cmd_byte_i[6:3] == 4'hD && cmd_byte_i[1] |=> rst_seq)
      else $error("soft reset sequence wrong");
   a_blink_rate: assert property (take && cmd_byte_i[6:3] == 4'hE |=> cfg_o.blink_rate == $past(cmd_byte_i[1:0]))
      else $error("blink rate not latched");
   a_all_pixels: assert property (take && cmd_byte_i[6:2] == 5'h1F |=> cfg_o.all_pixels == $past(cmd_byte_i[1:0]))
      else $error("all pixels not latched");
   a_undef_hold: assert property (take && cmd_byte_i[5] == cmd_byte_i[6] && !cmd_byte_i[5] |=> $stable(cfg_o))
      else $error("undefined command changed settings");
   a_force_on: assert property (pixels_force_on_o == (display_on_i && cfg_o.all_pixels == 2'h2))
      else $error("force on wrong");
   a_force_off: assert property (pixels_force_off_o == (display_on_i && cfg_o.all_pixels[0]))
      else $error("force off wrong");
   a_tick_pulse: assert property (frame_tick_o |=> !frame_tick_o)
      else $error("frame tick longer than one cycle");
   a_blink_off: assert property (cfg_o.blink_rate == 2'h0 |=> !blink_blank_o)
      else $error("blank phase while blink off");
endmodule

// >>> lcdcd_host.sv
// Host model presenting command bytes to the decoder
`timescale 1ns/100ps
module lcdcd_host (
   input wire logic mclk_i,
   output logic [7:0] cmd_byte_o,
   output logic cmd_valid_o
);
   initial begin
      cmd_byte_o = 8'h00;
      cmd_valid_o = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      @(negedge mclk_i);
      cmd_byte_o = b;
      cmd_valid_o = 1'b1;
   endtask
   // Stale byte inverted so idle data never looks valid
   task automatic idle();
      @(negedge mclk_i);
      cmd_byte_o = ~cmd_byte_o;
      cmd_valid_o = 1'b0;
   endtask
endmodule

// >>> lcdcd_map.svh
// Command encodings, field positions, reset values and timing counts
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH
`define LCDCD_CTL_BIT 7
`define LCDCD_DC_PAT 2'h1
`define LCDCD_OSC_PAT 4'hD
`define LCDCD_BLK_PAT 4'hE
`define LCDCD_ALL_PAT 5'h1F
`define LCDCD_CUR_RST 2'h2
`define LCDCD_FRM_RST 2'h0
`define LCDCD_BLK_RST 2'h0
`define LCDCD_ALL_RST 2'h0
`define LCDCD_WAVE_BIT 2
`define LCDCD_CLK_HZ 25000000
// Frame tick per row period: frame rate times four commons
`define LCDCD_FRM_DIV(f) ((`LCDCD_CLK_HZ / ((f) * 4)) - 1)
`define LCDCD_FRM_80 24'(`LCDCD_FRM_DIV(80))
`define LCDCD_FRM_71 24'(`LCDCD_FRM_DIV(71))
`define LCDCD_FRM_64 24'(`LCDCD_FRM_DIV(64))
`define LCDCD_FRM_53 24'(`LCDCD_FRM_DIV(53))
// Blink toggles twice per period
`define LCDCD_BLK_05 26'((`LCDCD_CLK_HZ) - 1)
`define LCDCD_BLK_1 26'((`LCDCD_CLK_HZ / 2) - 1)
`define LCDCD_BLK_2 26'((`LCDCD_CLK_HZ / 4) - 1)
`endif

// >>> lcdcd_pkg.sv
// Types for the LCD configuration command decoder
package lcdcd_pkg;
   typedef enum logic [1:0] {
      LCDCD_CUR_LOW2 = 2'h0,
      LCDCD_CUR_LOW1 = 2'h1,
      LCDCD_CUR_NORM = 2'h2,
      LCDCD_CUR_HIGH = 2'h3
   } lcdcd_cur_t;
   typedef struct packed {
      lcdcd_cur_t current_mode;
      logic waveform_select_bit;
      logic [1:0] frame_freq;
      logic osc_source_bit;
      logic [1:0] blink_rate;
      logic [1:0] all_pixels;
   } lcdcd_cfg_t;
   typedef struct packed {
      lcdcd_cfg_t cfg;
      logic soft_reset;
      logic [23:0] frm_cnt;
      logic frm_tick;
      logic [25:0] blk_cnt;
      logic blk_phase;
      logic [2:0] ext_sync;
      logic ext_level;
      logic ext_rise;
   } lcdcd_state_t;
endpackage

// >>> lcdcd_top.sv
// LCD configuration command decoder: command byte decode and settings
`timescale 1ns/100ps
`include "lcdcd_map.svh"
module lcdcd_top
   import lcdcd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] cmd_byte_i,
   input wire logic cmd_valid_i,
   input wire logic ext_clock_in_i,
   input wire logic display_on_i,
   output lcdcd_cfg_t cfg_o,
   output logic soft_reset_o,
   output logic frame_tick_o,
   output logic blink_blank_o,
   output logic pixels_force_on_o,
   output logic pixels_force_off_o
);
   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic [23:0] frame_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: frame_limit = `LCDCD_FRM_80;
         2'h1: frame_limit = `LCDCD_FRM_71;
         2'h2: frame_limit = `LCDCD_FRM_64;
         2'h3: frame_limit = `LCDCD_FRM_53;
      endcase
   endfunction

   function automatic logic [25:0] blink_limit(input logic [1:0] sel);
      unique case (sel)
         2'h1: blink_limit = `LCDCD_BLK_05;
         2'h2: blink_limit = `LCDCD_BLK_1;
         2'h3: blink_limit = `LCDCD_BLK_2;
         default: blink_limit = `LCDCD_BLK_05;
      endcase
   endfunction

   function automatic lcdcd_cfg_t reset_cfg();
      lcdcd_cfg_t c;
      c.current_mode = lcdcd_cur_t'(`LCDCD_CUR_RST);
      c.waveform_select_bit = 1'b0;
      c.frame_freq = `LCDCD_FRM_RST;
      c.osc_source_bit = 1'b0;
      c.blink_rate = `LCDCD_BLK_RST;
      c.all_pixels = `LCDCD_ALL_RST;
      reset_cfg = c;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   lcdcd_state_t state_q;
   lcdcd_state_t state_d;
   logic is_cmd;
   logic osc_step;

   always_comb begin
      state_d = state_q;
      // Command strobe is a valid byte with bit 7 set; no acknowledge involved
      is_cmd = cmd_valid_i & cmd_byte_i[`LCDCD_CTL_BIT];
      state_d.soft_reset = 1'b0;
      if (state_q.soft_reset) begin
         state_d.cfg = reset_cfg();
      end else if (is_cmd) begin
         if (cmd_byte_i[6:5] == `LCDCD_DC_PAT) begin
            state_d.cfg.current_mode = lcdcd_cur_t'(cmd_byte_i[1:0]);
            state_d.cfg.waveform_select_bit = cmd_byte_i[`LCDCD_WAVE_BIT];
            state_d.cfg.frame_freq = cmd_byte_i[4:3];
         end else if (cmd_byte_i[6:3] == `LCDCD_OSC_PAT) begin
            state_d.cfg.osc_source_bit = cmd_byte_i[0];
            state_d.soft_reset = cmd_byte_i[1];
         end else if (cmd_byte_i[6:3] == `LCDCD_BLK_PAT) begin
            state_d.cfg.blink_rate = cmd_byte_i[1:0];
         end else if (cmd_byte_i[6:2] == `LCDCD_ALL_PAT) begin
            state_d.cfg.all_pixels = cmd_byte_i[1:0];
         end
         // Other patterns fall through untouched
      end

      // External clock passes three flops; edge counts once last two agree
      state_d.ext_sync = {state_q.ext_sync[1:0], ext_clock_in_i};
      state_d.ext_rise = 1'b0;
      if (state_q.ext_sync[2] == state_q.ext_sync[1]) begin
         state_d.ext_level = state_q.ext_sync[2];
         state_d.ext_rise = state_q.ext_sync[2] & ~state_q.ext_level;
      end
      // Oscillator source picks the frame timebase
      osc_step = state_q.cfg.osc_source_bit ? state_q.ext_rise : 1'b1;

      state_d.frm_tick = 1'b0;
      if (osc_step) begin
         if (state_q.frm_cnt >= frame_limit(state_q.cfg.frame_freq)) begin
            state_d.frm_cnt = 24'h000000;
            state_d.frm_tick = 1'b1;
         end else begin
            state_d.frm_cnt = state_q.frm_cnt + 24'h000001;
         end
      end

      // Blink timebase always from the system clock
      if (state_q.cfg.blink_rate == 2'h0) begin
         state_d.blk_cnt = 26'h0000000;
         state_d.blk_phase = 1'b0;
      end else if (state_q.blk_cnt >= blink_limit(state_q.cfg.blink_rate)) begin
         state_d.blk_cnt = 26'h0000000;
         state_d.blk_phase = ~state_q.blk_phase;
      end else begin
         state_d.blk_cnt = state_q.blk_cnt + 26'h0000001;
      end

      // Soft reset also clears the timebases
      if (state_q.soft_reset) begin
         state_d.frm_cnt = 24'h000000;
         state_d.blk_cnt = 26'h0000000;
         state_d.blk_phase = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q.cfg <= reset_cfg();
         state_q.soft_reset <= 1'b0;
         state_q.frm_cnt <= 24'h000000;
         state_q.frm_tick <= 1'b0;
         state_q.blk_cnt <= 26'h0000000;
         state_q.blk_phase <= 1'b0;
         state_q.ext_sync <= 3'h0;
         state_q.ext_level <= 1'b0;
         state_q.ext_rise <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Override gated by display on; RAM never written here
   assign cfg_o = state_q.cfg;
   assign soft_reset_o = state_q.soft_reset;
   assign frame_tick_o = state_q.frm_tick;
   assign blink_blank_o = state_q.blk_phase;
   assign pixels_force_on_o = display_on_i & (state_q.cfg.all_pixels == 2'h2);
   assign pixels_force_off_o = display_on_i & state_q.cfg.all_pixels[0];
endmodule

// >>> tb_top.sv
// Table driven testbench for the command decoder
`timescale 1ns/100ps
module tb_top
   import lcdcd_pkg::*;
;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic disp = 1'b0;
   logic [7:0] cmd_byte;
   logic cmd_valid;
   lcdcd_cfg_t cfg;
   logic soft_rst, tick, blank, f_on, f_off;
   int error_cnt = 0;
   int checks = 0;
   // Byte beside the settings expected after it
   logic [17:0] rows [15] = '{18'({8'hB5, 10'h1C0}), 18'({8'hAA, 10'h220}), 18'({8'hBB, 10'h360}),
      18'({8'hA4, 10'h080}), 18'({8'hED, 10'h090}), 18'({8'hF5, 10'h094}), 18'({8'hF2, 10'h098}),
      18'({8'hF7, 10'h09C}), 18'({8'hFD, 10'h09D}), 18'({8'hFE, 10'h09E}), 18'({8'hFF, 10'h09F}),
      18'({8'h35, 10'h09F}), 18'({8'h88, 10'h09F}), 18'({8'hC8, 10'h09F}), 18'({8'hFC, 10'h09C})};
   lcdcd_host lcdcd_host_inst (.mclk_i(mclk_i), .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid));
   // External clock left still: frame counts too long to reach here
   lcdcd_top lcdcd_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_byte_i(cmd_byte),
      .cmd_valid_i(cmd_valid), .ext_clock_in_i(1'b0), .display_on_i(disp), .cfg_o(cfg),
      .soft_reset_o(soft_rst), .frame_tick_o(tick), .blink_blank_o(blank),
      .pixels_force_on_o(f_on), .pixels_force_off_o(f_off));
   initial forever #20 mclk_i = ~mclk_i;
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (8) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      chk("reset cfg", 10'h200, cfg);
      chk("reset outs", 10'h000, 10'({soft_rst, tick, blank, f_on, f_off}));
      foreach (rows[i]) begin
         disp = i[0];
         lcdcd_host_inst.send(rows[i][17:10]);
         lcdcd_host_inst.idle();
         chk("cfg", rows[i][9:0], cfg);
         chk("force", 10'({disp && rows[i][1:0] == 2'h2, disp && rows[i][0]}), 10'({f_on, f_off}));
      end
      // Back to back: second byte lands in the reset pulse and is lost
      lcdcd_host_inst.send(8'hEB);
      lcdcd_host_inst.send(8'hB5);
      chk("soft reset", 10'h001, 10'(soft_rst));
      lcdcd_host_inst.idle();
      chk("after reset", 10'h200, cfg);
      chk("pulse end", 10'h000, 10'({soft_rst, blank}));
      final_report();
   end
endmodule
bind lcdcd_top lcdcd_chk lcdcd_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_byte_i(cmd_byte_i),
   .cmd_valid_i(cmd_valid_i), .display_on_i(display_on_i), .cfg_o(cfg_o), .soft_reset_o(soft_reset_o),
   .pixels_force_on_o(pixels_force_on_o), .pixels_force_off_o(pixels_force_off_o),
   .frame_tick_o(frame_tick_o), .blink_blank_o(blink_blank_o));
